/* logic/icfg_map.svh */
// Purpose: Offsets, field positions and reset values of the input clock configuration page.
// Assumes: Byte-wide registers, one byte address each.
// Notes: Definitions only.
`ifndef ICFG_MAP_SVH
`define ICFG_MAP_SVH
// Page numbers
`define ICFG_PAGE_CLKMON 8'h01
`define ICFG_PAGE_INPUT 8'h02
// Offsets, monitor page
`define ICFG_OFS_SYNTH_B_SEL 8'h49
`define ICFG_OFS_SYNTH_C_SEL 8'h4A
`define ICFG_OFS_SYNTH_D_SEL 8'h4B
`define ICFG_OFS_IN3_SET_FINE 8'h4C
`define ICFG_OFS_IN2_SET_FINE 8'h4D
`define ICFG_OFS_IN1_SET_FINE 8'h4E
`define ICFG_OFS_IN0_SET_FINE 8'h4F
`define ICFG_OFS_IN3_CLR_FINE 8'h32
`define ICFG_OFS_IN2_CLR_FINE 8'h33
`define ICFG_OFS_IN1_CLR_FINE 8'h34
`define ICFG_OFS_IN0_CLR_FINE 8'h35
`define ICFG_OFS_PAGE 8'hFF
// Offsets, input system page
`define ICFG_OFS_DIRECTIVE 8'h0F
`define ICFG_OFS_IN0_RATIO_LO 8'h10
`define ICFG_OFS_IN0_RATIO_HI 8'h11
`define ICFG_OFS_IN0_CFG1 8'h1A
`define ICFG_OFS_IN0_CFG2 8'h1B
`define ICFG_OFS_IN0_RAMP_CFG 8'h1C
`define ICFG_OFS_IN0_CFG4 8'h1D
`define ICFG_OFS_IN0_RAMP_DIV 8'h1E
`define ICFG_MIRROR_LO 8'h10
`define ICFG_MIRROR_HI 8'h4F
// Field positions
`define ICFG_BIT_PRIMARY 6
`define ICFG_BIT_BACKUP0 4
`define ICFG_BIT_BACKUP1 2
`define ICFG_BIT_BACKUP2 0
`define ICFG_BIT_DIR_CODE 3
`define ICFG_BIT_ESCAPE 1
`define ICFG_BIT_INT_MODE 7
`define ICFG_BIT_RAMP_EN 6
`define ICFG_BIT_BYPASS 5
`define ICFG_BIT_SINGLE 4
// Directive codes
`define ICFG_DIR_BURN_FUSE 5'h18
`define ICFG_DIR_READ_FUSE 5'h0C
`define ICFG_DIR_COPY_NVM 5'h06
`define ICFG_DIR_PROCEED 5'h1B
// Reset values
`define ICFG_RST_BYTE 8'h00
`define ICFG_RST_PAGE 8'h00
`endif

/* logic/icfg_pkg.sv */
// Purpose: Types shared by the input clock configuration page.
// Assumes: Constants live in icfg_map.svh.
// Notes: None.
package icfg_pkg;
  typedef enum logic [0:0] {
    ICFG_ST_COMMAND = 1'b0,
    ICFG_ST_ACTIVE = 1'b1
  } icfg_state_t;

  typedef struct packed {
    logic [1:0] primary;
    logic [1:0] backup0;
    logic [1:0] backup1;
    logic [1:0] backup2;
  } icfg_src_sel_t;

  typedef struct packed {
    logic [15:0] ratio;
    logic int_mode;
    logic ramp_en;
    logic bypass;
    logic single_ended;
    logic [3:0] ref_osc_div;
    logic [3:0] in_div;
    logic [7:0] ramp_cfg;
  } icfg_in0_cfg_t;

  typedef struct packed {
    logic burn_fuse;
    logic read_fuse;
    logic copy_nvm;
  } icfg_cmd_t;
endpackage : icfg_pkg

/* logic/icfg_thr_scale.sv */
// Purpose: Scale programmed fine drift thresholds to the applied value.
// Assumes: Four inputs.
// Notes: Purely combinational.
`timescale 1ns/100ps
module icfg_thr_scale
  import icfg_pkg::*;
#(
  parameter int NUM_IN = 4
) (
  // Programmed values
  input wire logic [NUM_IN*8-1:0] FINE_IN,
  // Applied values
  output logic [NUM_IN*9-1:0] THR_OUT
);
  // Doubling is a shift, so no multiplier is spent
  always_comb begin
    for (int i = 0; i < NUM_IN; i++) begin
      THR_OUT[i*9 +: 9] = {FINE_IN[i*8 +: 8], 1'b0};
    end
  end
endmodule : icfg_thr_scale

/* logic/icfg_page.sv */
// Overview of operation
// - Primary source field picks input 0-3
// - Three backup fields pick input 0-3
// - Applied set threshold is twice programmed
// - Page select register at top, every page
// - Input page 10h-4Fh mirrors NVM copies
// - Decode burn, read fuse, copy NVM
// - Proceed code enters active state
// - Escape bit returns to command state
// - Input 0 ratio spans three fields
// - Bit 7 selects integer-only division
// - Bit 6 enables frequency ramp monitoring
// - Bit 5 bypasses first-stage divider
// - Bit 4 selects single-ended receiver
// - Ramp divider nibbles: oscillator, input 0
// - Ramp monitor bits applied unchanged
// - Applied clear threshold is twice programmed
//
// Purpose: Paged byte register bank for input clock selection and monitor setup.
// Assumes: Serial bus front end delivers byte strobes synchronous to CLK.
// Notes: Reads are registered, valid one cycle after the strobe.
`timescale 1ns/100ps
`include "icfg_map.svh"
module icfg_page
  import icfg_pkg::*;
#(
  parameter int NUM_IN = 4,
  parameter logic [7:0] MIRROR_LO = `ICFG_MIRROR_LO,
  parameter logic [7:0] MIRROR_HI = `ICFG_MIRROR_HI
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // Register access from the serial bus front end
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  output logic REG_RVALID,
  // Non-volatile copy load into live settings
  input wire logic [7:0] NVM_WADDR,
  input wire logic [7:0] NVM_WDATA,
  input wire logic NVM_WE,
  // Synth source selection
  output icfg_src_sel_t SECOND_SYNTH_SEL,
  output icfg_src_sel_t THIRD_SYNTH_SEL,
  output icfg_src_sel_t FOURTH_SYNTH_SEL,
  // Drift monitor thresholds, doubled
  output logic [NUM_IN*9-1:0] DRIFT_SET_THR,
  output logic [NUM_IN*9-1:0] DRIFT_CLR_THR,
  // Input clock 0 settings
  output icfg_in0_cfg_t INPUT_CLOCK_0_CFG,
  // Programming state and commands
  output logic ACTIVE_STATE,
  output icfg_cmd_t PROG_CMD,
  output logic [7:0] PAGE_SEL
);

  // Storage: one byte array per paged area
  logic [7:0] mon_q [0:255];
  logic [7:0] inp_q [0:255];
  logic [7:0] page_q;
  logic [7:0] rdata_q;
  logic rvalid_q;
  icfg_state_t state_q;
  icfg_cmd_t cmd_q;
  logic [NUM_IN*8-1:0] set_fine;
  logic [NUM_IN*8-1:0] clr_fine;
  logic wr_mon;
  logic wr_inp;
  logic [4:0] dir_code;

  // Is this offset one the bank implements on the monitor page
  function automatic logic mon_hit(input logic [7:0] a);
    mon_hit = (a >= `ICFG_OFS_IN3_CLR_FINE && a <= `ICFG_OFS_IN0_CLR_FINE) ||
              (a >= `ICFG_OFS_SYNTH_B_SEL && a <= `ICFG_OFS_IN0_SET_FINE);
  endfunction : mon_hit

  // Same question for the input system page
  function automatic logic inp_hit(input logic [7:0] a);
    inp_hit = (a == `ICFG_OFS_DIRECTIVE) || (a >= MIRROR_LO && a <= MIRROR_HI);
  endfunction : inp_hit

  // Page routing for ordinary addresses
  assign wr_mon = REG_WR && REG_ADDR != `ICFG_OFS_PAGE && page_q == `ICFG_PAGE_CLKMON
                  && mon_hit(REG_ADDR);
  assign wr_inp = REG_WR && REG_ADDR != `ICFG_OFS_PAGE && page_q == `ICFG_PAGE_INPUT
                  && inp_hit(REG_ADDR);
  assign dir_code = REG_WDATA[`ICFG_BIT_DIR_CODE +: 5];

  // Page select register, same on every page
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      page_q <= `ICFG_RST_PAGE;
    end else if (REG_WR && REG_ADDR == `ICFG_OFS_PAGE) begin
      page_q <= REG_WDATA;
    end
  end

  // Monitor page bytes
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      for (int i = 0; i < 256; i++) begin
        mon_q[i] <= `ICFG_RST_BYTE;
      end
    end else if (wr_mon) begin
      mon_q[REG_ADDR] <= REG_WDATA;
    end
  end

  // Input page bytes; host write wins over a simultaneous NVM load
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      for (int i = 0; i < 256; i++) begin
        inp_q[i] <= `ICFG_RST_BYTE;
      end
    end else begin
      if (NVM_WE && NVM_WADDR >= MIRROR_LO && NVM_WADDR <= MIRROR_HI) begin
        inp_q[NVM_WADDR] <= NVM_WDATA;
      end
      if (wr_inp) begin
        inp_q[REG_ADDR] <= REG_WDATA;
      end
    end
  end

  // Programming state machine
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_q <= ICFG_ST_COMMAND;
    end else if (wr_inp && REG_ADDR == `ICFG_OFS_DIRECTIVE) begin
      unique case (state_q)
        ICFG_ST_COMMAND: begin
          if (dir_code == `ICFG_DIR_PROCEED) begin
            state_q <= ICFG_ST_ACTIVE;
          end
        end
        ICFG_ST_ACTIVE: begin
          if (REG_WDATA[`ICFG_BIT_ESCAPE]) begin
            state_q <= ICFG_ST_COMMAND;
          end
        end
      endcase
    end
  end

  // Directive pulses, only honoured in the command state
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      cmd_q <= '0;
    end else begin
      cmd_q <= '0;
      if (wr_inp && REG_ADDR == `ICFG_OFS_DIRECTIVE && state_q == ICFG_ST_COMMAND) begin
        cmd_q.burn_fuse <= (dir_code == `ICFG_DIR_BURN_FUSE);
        cmd_q.read_fuse <= (dir_code == `ICFG_DIR_READ_FUSE);
        cmd_q.copy_nvm <= (dir_code == `ICFG_DIR_COPY_NVM);
      end
    end
  end

  // Registered read path; unmapped offsets read zero
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rdata_q <= `ICFG_RST_BYTE;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= REG_RD;
      if (REG_RD) begin
        if (REG_ADDR == `ICFG_OFS_PAGE) begin
          rdata_q <= page_q;
        end else if (page_q == `ICFG_PAGE_CLKMON && mon_hit(REG_ADDR)) begin
          rdata_q <= mon_q[REG_ADDR];
        end else if (page_q == `ICFG_PAGE_INPUT && inp_hit(REG_ADDR)) begin
          rdata_q <= inp_q[REG_ADDR];
        end else begin
          rdata_q <= `ICFG_RST_BYTE;
        end
      end
    end
  end

  assign REG_RDATA = rdata_q;
  assign REG_RVALID = rvalid_q;
  assign PAGE_SEL = page_q;
  assign ACTIVE_STATE = (state_q == ICFG_ST_ACTIVE);
  assign PROG_CMD = cmd_q;

  // Source fields straight from the byte, same 0-3 encoding
  assign SECOND_SYNTH_SEL = icfg_src_sel_t'(mon_q[`ICFG_OFS_SYNTH_B_SEL]);
  assign THIRD_SYNTH_SEL = icfg_src_sel_t'(mon_q[`ICFG_OFS_SYNTH_C_SEL]);
  assign FOURTH_SYNTH_SEL = icfg_src_sel_t'(mon_q[`ICFG_OFS_SYNTH_D_SEL]);

  // Gather fine thresholds, input 0 in the low byte
  always_comb begin
    set_fine = '0;
    clr_fine = '0;
    for (int i = 0; i < NUM_IN; i++) begin
      set_fine[i*8 +: 8] = mon_q[`ICFG_OFS_IN0_SET_FINE - 8'(i)];
      clr_fine[i*8 +: 8] = mon_q[`ICFG_OFS_IN0_CLR_FINE - 8'(i)];
    end
  end

  // Doubling of set thresholds
  icfg_thr_scale #(.NUM_IN(NUM_IN)) u_set_scale (
    .FINE_IN(set_fine),
    .THR_OUT(DRIFT_SET_THR)
  );

  // Doubling of clear thresholds
  icfg_thr_scale #(.NUM_IN(NUM_IN)) u_clr_scale (
    .FINE_IN(clr_fine),
    .THR_OUT(DRIFT_CLR_THR)
  );

  // Input clock 0 fields; ratio is low byte, six bits, then two top bits
  always_comb begin
    INPUT_CLOCK_0_CFG.ratio = {inp_q[`ICFG_OFS_IN0_CFG1][7:6], inp_q[`ICFG_OFS_IN0_RATIO_HI][5:0],
                               inp_q[`ICFG_OFS_IN0_RATIO_LO]};
    INPUT_CLOCK_0_CFG.int_mode = inp_q[`ICFG_OFS_IN0_RATIO_HI][`ICFG_BIT_INT_MODE];
    INPUT_CLOCK_0_CFG.ramp_en = inp_q[`ICFG_OFS_IN0_RATIO_HI][`ICFG_BIT_RAMP_EN];
    INPUT_CLOCK_0_CFG.bypass = inp_q[`ICFG_OFS_IN0_CFG1][`ICFG_BIT_BYPASS];
    INPUT_CLOCK_0_CFG.single_ended = inp_q[`ICFG_OFS_IN0_CFG1][`ICFG_BIT_SINGLE];
    INPUT_CLOCK_0_CFG.ref_osc_div = inp_q[`ICFG_OFS_IN0_RAMP_DIV][7:4];
    INPUT_CLOCK_0_CFG.in_div = inp_q[`ICFG_OFS_IN0_RAMP_DIV][3:0];
    INPUT_CLOCK_0_CFG.ramp_cfg = inp_q[`ICFG_OFS_IN0_RAMP_CFG];
  end

endmodule : icfg_page

/* bench/icfg_page_monitor.sv */
// Purpose: Port checker for icfg_page
// Assumes: Page 1 monitor, page 2 input system
// Notes: Bound below by port name
`timescale 1ns/100ps
module icfg_page_monitor
  import icfg_pkg::*;
#(parameter int NUM_IN = 4) (
  // Clock and host strobes
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_RVALID,
  // Settings
  input wire icfg_src_sel_t SECOND_SYNTH_SEL,
  input wire logic [NUM_IN*9-1:0] DRIFT_SET_THR,
  input wire logic ACTIVE_STATE,
  input wire icfg_cmd_t PROG_CMD,
  input wire logic [7:0] PAGE_SEL
);
  // Page-qualified writes; unmapped pages never match
  logic mon_wr;
  logic dir_wr;
  assign mon_wr = REG_WR && PAGE_SEL == 8'h01;
  assign dir_wr = REG_WR && PAGE_SEL == 8'h02 && REG_ADDR == 8'h0F;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  read_answer_a: assert property (REG_RD |=> REG_RVALID)
    else $error("read unanswered");
  page_write_a: assert property (REG_WR && REG_ADDR == 8'hFF |=> PAGE_SEL == $past(REG_WDATA))
    else $error("page not taken");
  proceed_code_a: assert property (dir_wr && !ACTIVE_STATE && REG_WDATA[7:3] == 5'h1B |=> ACTIVE_STATE)
    else $error("proceed ignored");
  escape_bit_a: assert property (ACTIVE_STATE && dir_wr && REG_WDATA[1] |=> !ACTIVE_STATE)
    else $error("escape ignored");
  cmd_cause_a: assert property (PROG_CMD != 3'b000 |-> $past(dir_wr && !ACTIVE_STATE))
    else $error("command without directive");
  burn_code_a: assert property (dir_wr && !ACTIVE_STATE && REG_WDATA[7:3] == 5'h18 |=> PROG_CMD == 3'b100)
    else $error("burn not decoded");
  set_double_a: assert property (mon_wr && REG_ADDR == 8'h4F |=> DRIFT_SET_THR[8:0] == {$past(REG_WDATA), 1'b0})
    else $error("threshold not doubled");
  src_select_a: assert property (mon_wr && REG_ADDR == 8'h49 |=> SECOND_SYNTH_SEL == $past(REG_WDATA))
    else $error("source select wrong");
  // Main scenarios reached
  cover property (dir_wr && REG_WDATA[7:3] == 5'h1B);
  cover property (PROG_CMD.copy_nvm);
  cover property (REG_RVALID && PAGE_SEL == 8'h03);
endmodule : icfg_page_monitor
bind icfg_page icfg_page_monitor #(.NUM_IN(NUM_IN)) u_mon (.*);

/* bench/icfg_host.sv */
// Purpose: Host model on the register strobes
// Assumes: One access per call, idle edge between
// Notes: Released lines carry inverted values
`timescale 1ns/100ps
module icfg_host (
  // Clock and read return
  input wire logic CLK,
  input wire logic [7:0] REG_RDATA,
  // Register strobes
  output logic REG_WR,
  output logic REG_RD,
  output logic [7:0] REG_ADDR,
  output logic [7:0] REG_WDATA,
  // Copy load
  output logic NVM_WE,
  output logic [7:0] NVM_WADDR,
  output logic [7:0] NVM_WDATA
);
  // Quiet at time zero
  initial begin
    {REG_WR, REG_RD, NVM_WE} = 3'b000;
    {REG_ADDR, REG_WDATA, NVM_WADDR, NVM_WDATA} = 32'h0000_0000;
  end
  // Kind 0 read, 1 write, 2 copy load; page is the one last put in FFh
  task automatic acc(input logic [1:0] k, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge CLK);
    REG_RD <= k == 2'd0;
    REG_WR <= k == 2'd1;
    NVM_WE <= k == 2'd2;
    {REG_ADDR, NVM_WADDR} <= {a, a};
    {REG_WDATA, NVM_WDATA} <= {d, d};
    @(posedge CLK);
    {REG_WR, REG_RD, NVM_WE} <= 3'b000;
    // Stale values would hide a design that ignores the strobe
    {REG_ADDR, NVM_WADDR} <= ~{a, a};
    {REG_WDATA, NVM_WDATA} <= ~{d, d};
    #1;
    q = REG_RDATA;
  endtask : acc
endmodule : icfg_host

/* bench/input_clock_config_page_tb_top.sv */
// Purpose: Self-checking bench for icfg_page
// Assumes: Host model owns every strobe
// Notes: Page 3 stands for an unmapped page
`timescale 1ns/100ps
module input_clock_config_page_tb_top
  import icfg_pkg::*;
;
  logic CLK = 1'b0;
  logic RESETN = 1'b0;
  logic REG_WR, REG_RD, REG_RVALID, NVM_WE, ACTIVE_STATE;
  logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA, NVM_WADDR, NVM_WDATA, PAGE_SEL, q;
  logic [35:0] DRIFT_SET_THR, DRIFT_CLR_THR;
  icfg_src_sel_t SECOND_SYNTH_SEL, THIRD_SYNTH_SEL, FOURTH_SYNTH_SEL;
  icfg_in0_cfg_t INPUT_CLOCK_0_CFG;
  icfg_cmd_t PROG_CMD;
  int n_errors = 0;
  int checks = 0;
  logic [7:0] thr [4] = '{8'hFF, 8'h80, 8'h01, 8'h7F};
  logic [4:0] code [3] = '{5'h18, 5'h0C, 5'h06};
  icfg_page u_dut (.*);
  icfg_host u_host (.*);
  // Clock, 40 ns period
  initial forever #20 CLK = ~CLK;
  // Compare and count
  task automatic chk(input string nm, input logic [35:0] got, input logic [35:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // Verdict and end of run
  task automatic test_done();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : test_done
  // Short host access helpers
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_host.acc(2'd1, a, d, q);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    u_host.acc(2'd0, a, 8'h00, q);
    chk("read", q, e);
    chk("rvalid", REG_RVALID, 1'b1);
  endtask : rdc
  // Hang guard, well past the roughly 80 cycles used
  initial begin
    repeat (3000) @(posedge CLK);
    n_errors++;
    test_done();
  end
  // Main sequence
  initial begin
    repeat (10) @(posedge CLK);
    RESETN <= 1'b1;
    rdc(8'hFF, 8'h00);
    chk("state", ACTIVE_STATE, 1'b0);
    wr(8'hFF, 8'h01);
    for (int i = 0; i < 3; i++) begin
      wr(8'(8'h49 + i), 8'hE4 ^ 8'(i * 8'h55));
      chk("synth", 8'({FOURTH_SYNTH_SEL, THIRD_SYNTH_SEL, SECOND_SYNTH_SEL} >> (8 * i)), 8'hE4 ^ 8'(i * 8'h55));
    end
    for (int i = 0; i < 4; i++) begin
      wr(8'(8'h4F - i), thr[i]);
      wr(8'(8'h35 - i), ~thr[i]);
      chk("set thr", DRIFT_SET_THR[9*i +: 9], {thr[i], 1'b0});
      chk("clr thr", DRIFT_CLR_THR[9*i +: 9], {~thr[i], 1'b0});
    end
    // Same offset on other pages must not touch page 1
    wr(8'hFF, 8'h02);
    wr(8'h49, 8'h11);
    rdc(8'h49, 8'h11);
    wr(8'hFF, 8'h03);
    wr(8'h49, 8'h5A);
    rdc(8'h49, 8'h00);
    rdc(8'hFF, 8'h03);
    chk("page", PAGE_SEL, 8'h03);
    chk("kept", SECOND_SYNTH_SEL, 8'hE4);
    wr(8'hFF, 8'h02);
    wr(8'h10, 8'hA6);
    wr(8'h11, 8'hF5);
    wr(8'h1A, 8'hB0);
    wr(8'h1C, 8'h5A);
    wr(8'h1E, 8'h9C);
    chk("in0", INPUT_CLOCK_0_CFG, {16'hB5A6, 4'hF, 8'h9C, 8'h5A});
    wr(8'h11, 8'h35);
    wr(8'h1A, 8'h40);
    chk("in0 off", INPUT_CLOCK_0_CFG[35:16], {16'h75A6, 4'h0});
    u_host.acc(2'd2, 8'h1C, 8'hC3, q);
    chk("copy", INPUT_CLOCK_0_CFG.ramp_cfg, 8'hC3);
    for (int i = 0; i < 3; i++) begin
      wr(8'h0F, {code[i], 3'b000});
      chk("cmd", PROG_CMD, 3'b100 >> i);
    end
    wr(8'h0F, 8'hD8);
    chk("active", ACTIVE_STATE, 1'b1);
    wr(8'h0F, 8'hC0);
    chk("refused", PROG_CMD, 3'b000);
    wr(8'h0F, 8'h02);
    chk("escape", ACTIVE_STATE, 1'b0);
    rdc(8'h0F, 8'h02);
    test_done();
  end
endmodule : input_clock_config_page_tb_top
